// ==== core/pad_cell_ctrl.sv ====
`timescale 1ns/10ps
module pad_cell_ctrl
   import pad_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire pad_field_t cfg,
   input wire logic oe_req,
   output pad_drive_t pad
);

   // ==========================================================
   // Pad control outputs, registered.
   wire logic oe_next = oe_req & ~cfg.output_disable_bit;
   wire logic [3:0] ma_next = drive_ma_of(cfg.drive_code);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad <= '0;
      end else begin
         pad.oe <= oe_next;
         pad.input_en <= cfg.input_enable_bit;
         pad.drive_ma <= ma_next;
         pad.pull_up <= cfg.pull_up_bit;
         pad.pull_down <= cfg.pull_down_bit;
         pad.schmitt <= cfg.schmitt_bit;
         pad.fast_slew <= cfg.fast_edge_rate_bit;
      end
   end

   // ==========================================================
   // Checks.
   chk_disable_blocks_oe: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg.output_disable_bit |=> !pad.oe)
      else $error("output driver on while output disable set");

   chk_oe_passes: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (oe_req && !cfg.output_disable_bit) |=> pad.oe)
      else $error("output enable request lost");

   chk_drive_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg.drive_code == 2'h3 |=> pad.drive_ma == 4'hc)
      else $error("drive code 3 not decoded as 12 mA");

   chk_slew_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> pad.fast_slew == $past(cfg.fast_edge_rate_bit))
      else $error("edge rate select does not follow register");

endmodule

// ==== core/pad_control_register_bank.sv ====
// Overview of operation
// - A set output-disable bit keeps the pad driver off despite peripheral requests.
// - Drive code 0,1,2,3 selects 2, 4, 8 and 12 mA.
// - Bit 0 set selects fast edges, clear selects slow edges.
// - Flash bank level select: 0 is 3.3V, 1 is 1.8V; resets to 0.
// - Thirty user pad registers at 0x04 to 0x78, reset value 0x56.
// - Flash bank pad registers decode from base 0x40020000.
// - Flash bank: level select at 0x00, six pads at 0x04 to 0x18.
`timescale 1ns/10ps
module pad_control_register_bank
   import pad_ctrl_pkg::*;
#(
   parameter int USER_GP_PADS = 30,
   parameter int FLASH_PADS = 6
)(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [USER_GP_PADS+FLASH_PADS+1:0] oe_req,
   output pad_drive_t pad_out [USER_GP_PADS+FLASH_PADS+2],
   output logic flash_level_1v8
);

   localparam int NUM_PADS = USER_GP_PADS + FLASH_PADS + 2;
   localparam int FLASH_IDX0 = USER_GP_PADS + 2;

   // ==========================================================
   // Elaboration checks.
   if (USER_GP_PADS < 1 || USER_GP_PADS > 61 || FLASH_PADS < 1 ||
       FLASH_PADS > 63 || NUM_PADS > 64) begin : g_bad_counts
      $error("pad counts outside what the decoder can address");
   end

   // ==========================================================
   // Reset release.
   logic rst_n_meta;
   logic rst_n_sync;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rst_n_meta <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_n_meta <= 1'b1;
         rst_n_sync <= rst_n_meta;
      end
   end

   // ==========================================================
   // Address decode and reset values.
   function automatic reg_decode_t decode(input logic [31:0] a);
      reg_decode_t d;
      int word;
      d = '0;
      word = int'(a[7:2]);
      if (a[31:8] == USER_BANK_BASE[31:8] && a[1:0] == 2'h0 &&
          word >= 1 && word <= USER_GP_PADS + 2) begin
         d.hit = 1'b1;
         d.idx = 6'(word - 1);
      end else if (a[31:8] == FLASH_BANK_BASE[31:8] &&
                   a[1:0] == 2'h0) begin
         if (word == int'(LEVEL_SEL_OFS[7:2])) begin
            d.hit = 1'b1;
            d.level = 1'b1;
         end else if (word >= 1 && word <= FLASH_PADS) begin
            d.hit = 1'b1;
            d.idx = 6'(FLASH_IDX0 + word - 1);
         end
      end
      return d;
   endfunction

   function automatic pad_field_t reset_of(input int i);
      logic [7:0] v;
      if (i < USER_GP_PADS)
         v = USER_PAD_RESET;
      else if (i == USER_GP_PADS)
         v = DEBUG_CLK_RESET;
      else if (i == USER_GP_PADS + 1)
         v = DEBUG_DATA_RESET;
      else if (i == FLASH_IDX0)
         v = FLASH_CLK_RESET;
      else if (i == NUM_PADS - 1)
         v = FLASH_SEL_RESET;
      else
         v = FLASH_DATA_RESET;
      return pad_field_t'(v);
   endfunction

   // ==========================================================
   // Bus slave.
   logic wr_pend_reg;
   reg_decode_t wr_dec_reg;
   logic level_reg;
   pad_field_t pad_reg [NUM_PADS];

   wire logic addr_take = hsel & hready & htrans[1];
   wire reg_decode_t rd_dec = decode(haddr);
   wire reg_decode_t wr_dec_next = decode(haddr);
   wire pad_field_t rd_pad = pad_reg[rd_dec.idx];
   wire logic [31:0] rd_value = !rd_dec.hit ? 32'h0 :
      rd_dec.level ? {31'h0, level_reg} :
      {24'h0, rd_pad};
   wire logic [31:0] hrdata_next = (addr_take && !hwrite) ? rd_value :
      32'h0;
   wire logic wr_level = wr_pend_reg & wr_dec_reg.hit & wr_dec_reg.level;

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wr_pend_reg <= 1'b0;
         wr_dec_reg <= '0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_reg <= addr_take & hwrite;
         wr_dec_reg <= wr_dec_next;
         hrdata <= hrdata_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         level_reg <= LEVEL_SEL_RESET;
      end else if (wr_level) begin
         level_reg <= hwdata[0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         flash_level_1v8 <= LEVEL_SEL_RESET;
      end else begin
         flash_level_1v8 <= level_reg;
      end
   end

   // ==========================================================
   // Pad registers and pad controls.
   genvar i;
   generate
      for (i = 0; i < NUM_PADS; i++) begin : g_pad
         wire logic wr_this = wr_pend_reg & wr_dec_reg.hit &
            ~wr_dec_reg.level & (wr_dec_reg.idx == 6'(i));

         always_ff @(posedge ref_clk or negedge rst_n_sync) begin
            if (!rst_n_sync) begin
               pad_reg[i] <= reset_of(i);
            end else if (wr_this) begin
               pad_reg[i] <= pad_field_t'(hwdata[7:0]);
            end
         end

         pad_cell_ctrl u_cell (
            .ref_clk(ref_clk),
            .rst_n(rst_n_sync),
            .cfg(pad_reg[i]),
            .oe_req(oe_req[i]),
            .pad(pad_out[i])
         );
      end
   endgenerate

   // ==========================================================
   // Checks.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n_sync);

   logic post_reset_reg;

   always_ff @(posedge ref_clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         post_reset_reg <= 1'b1;
      end else begin
         post_reset_reg <= 1'b0;
      end
   end

   sequence wr_addr_phase(logic [31:0] a);
      addr_take && hwrite && haddr == a;
   endsequence

   sequence rd_addr_phase(logic [31:0] a);
      addr_take && !hwrite && haddr == a;
   endsequence

   property write_lands(logic [31:0] a, int k);
      logic [7:0] d;
      wr_addr_phase(a) ##1 (1'b1, d = hwdata[7:0]) |=> pad_reg[k] == d;
   endproperty

   chk_level_write: assert property (
      wr_addr_phase(FLASH_BANK_BASE) ##1 hwdata[0] |=> ##1 flash_level_1v8)
      else $error("level select write did not reach output");

   chk_user_reset: assert property (
      post_reset_reg |-> pad_reg[0] == pad_field_t'(USER_PAD_RESET) &&
         !level_reg)
      else $error("user pad or level select reset value wrong");

   chk_flash_base: assert property (
      write_lands(FLASH_BANK_BASE + 32'(FLASH_PAD_FIRST_OFS), FLASH_IDX0))
      else $error("flash clock pad write not decoded at bank base");

   chk_flash_layout: assert property (
      write_lands(FLASH_BANK_BASE + 32'(FLASH_PAD_LAST_OFS),
         FLASH_IDX0 + 5))
      else $error("flash select pad not at last flash offset");

   chk_reserved_zero: assert property (
      rd_addr_phase(FLASH_BANK_BASE) |=> hrdata == {31'h0, $past(level_reg)})
      else $error("level select read shows reserved bits");

endmodule

// ==== core/pad_ctrl_pkg.sv ====
package pad_ctrl_pkg;

   // ==========================================================
   // Address map.
   localparam logic [31:0] USER_BANK_BASE = 32'h4001c000;
   localparam logic [31:0] FLASH_BANK_BASE = 32'h40020000;
   localparam logic [7:0] USER_PAD_FIRST_OFS = 8'h04;
   localparam logic [7:0] USER_PAD_LAST_OFS = 8'h78;
   localparam logic [7:0] DEBUG_CLK_OFS = 8'h7c;
   localparam logic [7:0] DEBUG_DATA_OFS = 8'h80;
   localparam logic [7:0] LEVEL_SEL_OFS = 8'h00;
   localparam logic [7:0] FLASH_PAD_FIRST_OFS = 8'h04;
   localparam logic [7:0] FLASH_PAD_LAST_OFS = 8'h18;

   // ==========================================================
   // Values after reset.
   localparam logic [7:0] USER_PAD_RESET = 8'h56;
   localparam logic [7:0] DEBUG_CLK_RESET = 8'hda;
   localparam logic [7:0] DEBUG_DATA_RESET = 8'h5a;
   localparam logic [7:0] FLASH_CLK_RESET = 8'h56;
   localparam logic [7:0] FLASH_DATA_RESET = 8'h52;
   localparam logic [7:0] FLASH_SEL_RESET = 8'h5a;
   localparam logic LEVEL_SEL_RESET = 1'b0;

   // ==========================================================
   // Drive strength in milliamperes for each code.
   localparam logic [3:0] DRIVE_MA_CODE0 = 4'h2;
   localparam logic [3:0] DRIVE_MA_CODE1 = 4'h4;
   localparam logic [3:0] DRIVE_MA_CODE2 = 4'h8;
   localparam logic [3:0] DRIVE_MA_CODE3 = 4'hc;

   // ==========================================================
   // Field layout of one pad register, bit 7 first.
   typedef struct packed {
      logic output_disable_bit;
      logic input_enable_bit;
      logic [1:0] drive_code;
      logic pull_up_bit;
      logic pull_down_bit;
      logic schmitt_bit;
      logic fast_edge_rate_bit;
   } pad_field_t;

   typedef struct packed {
      logic oe;
      logic input_en;
      logic [3:0] drive_ma;
      logic pull_up;
      logic pull_down;
      logic schmitt;
      logic fast_slew;
   } pad_drive_t;

   typedef struct packed {
      logic hit;
      logic level;
      logic [5:0] idx;
   } reg_decode_t;

   function automatic logic [3:0] drive_ma_of(input logic [1:0] code);
      logic [3:0] ma;
      case (code)
         2'h0: ma = DRIVE_MA_CODE0;
         2'h1: ma = DRIVE_MA_CODE1;
         2'h2: ma = DRIVE_MA_CODE2;
         default: ma = DRIVE_MA_CODE3;
      endcase
      return ma;
   endfunction

endpackage

// ==== tb/test_pad_control_register_bank.sv ====
`timescale 1ns/10ps
module test_pad_control_register_bank
   import pad_ctrl_pkg::*;
;
   // ==========================================================
   // Stimulus and design.
   localparam int NP = 38;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [NP-1:0] oe_req = '1;
   pad_drive_t pad_out [NP];
   logic flash_level_1v8;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   logic [3:0] ma_tab [4] = '{4'h2, 4'h4, 4'h8, 4'hc};

   assign hready = hreadyout;

   pad_control_register_bank pad_control_register_bank_i (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .oe_req(oe_req),
      .pad_out(pad_out),
      .flash_level_1v8(flash_level_1v8)
   );

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // Checking and closing.
   task automatic test_done();
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ==========================================================
   // Bus tasks: address phase, then data phase, each held to hready.
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h0, q);
      chk(q, e);
      chk(32'(hresp), 32'h0);
   endtask

   // Pad outputs and the level output trail the register by a few edges.
   task automatic settle();
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic check_resets();
      for (int i = 0; i < 30; i++) begin
         rd_chk(USER_BANK_BASE + 32'h4 + 32'(4 * i), 32'h56);
      end
      rd_chk(USER_BANK_BASE + 32'h7c, 32'hda);
      rd_chk(USER_BANK_BASE + 32'h80, 32'h5a);
      rd_chk(FLASH_BANK_BASE, 32'h0);
      rd_chk(FLASH_BANK_BASE + 32'h4, 32'h56);
      for (int i = 0; i < 4; i++) begin
         rd_chk(FLASH_BANK_BASE + 32'h8 + 32'(4 * i), 32'h52);
      end
      rd_chk(FLASH_BANK_BASE + 32'h18, 32'h5a);
      settle();
      chk(32'(pad_out[0]), 32'h346);
      chk(32'(pad_out[30]), 32'h14a);
      chk(32'(flash_level_1v8), 32'h0);
   endtask

   // ==========================================================
   // Main sequence.
   initial begin
      do_reset();
      check_resets();
      for (int c = 0; c < 4; c++) begin
         wr(USER_BANK_BASE + 32'h4, 32'({2'h0, c[1:0], 3'h0, c[0]}));
         settle();
         chk(32'(pad_out[0].drive_ma), 32'(ma_tab[c]));
         chk(32'(pad_out[0].fast_slew), 32'(c[0]));
      end
      wr(USER_BANK_BASE + 32'h78, 32'hd6);
      settle();
      chk(32'(pad_out[29].oe), 32'h0);
      wr(USER_BANK_BASE + 32'h78, 32'h56);
      settle();
      chk(32'(pad_out[29].oe), 32'h1);
      @(posedge ref_clk);
      oe_req[29] <= 1'b0;
      settle();
      chk(32'(pad_out[29].oe), 32'h0);
      wr(FLASH_BANK_BASE + 32'h8, 32'h80);
      settle();
      chk(32'(pad_out[33].oe), 32'h0);
      chk(32'(pad_out[34].oe), 32'h1);
      wr(USER_BANK_BASE + 32'h8, 32'hffffffff);
      rd_chk(USER_BANK_BASE + 32'h8, 32'hff);
      wr(FLASH_BANK_BASE, 32'hffffffff);
      rd_chk(FLASH_BANK_BASE, 32'h1);
      settle();
      chk(32'(flash_level_1v8), 32'h1);
      wr(FLASH_BANK_BASE + 32'h18, 32'h0);
      rd_chk(FLASH_BANK_BASE + 32'h18, 32'h0);
      rd_chk(USER_BANK_BASE + 32'h18, 32'h56);
      wr(FLASH_BANK_BASE + 32'h4, 32'h5b);
      rd_chk(FLASH_BANK_BASE + 32'h4, 32'h5b);
      wr(FLASH_BANK_BASE + 32'h1c, 32'hff);
      rd_chk(FLASH_BANK_BASE + 32'h1c, 32'h0);
      rd_chk(USER_BANK_BASE + 32'h84, 32'h0);
      oe_req <= '1;
      do_reset();
      check_resets();
      test_done();
   end
endmodule
